/* File: rtl/cam_dma_pkg.sv */
// Holds offsets, field positions, reset values and fetch states for the camera DMA control.
// Assumes a 32-bit classic Wishbone slave and a 32-bit Wishbone memory master.
package cam_dma_pkg;
	localparam logic [7:0] OFF_ENABLE = 8'h00;
	localparam logic [7:0] OFF_DISABLE = 8'h04;
	localparam logic [7:0] OFF_STATE = 8'h08;
	localparam logic [7:0] OFF_P_BASE = 8'h0c;
	localparam logic [7:0] OFF_P_CTRL = 8'h10;
	localparam logic [7:0] OFF_P_DESC = 8'h14;
	localparam logic [7:0] OFF_C_BASE = 8'h18;
	localparam logic [7:0] OFF_C_CTRL = 8'h1c;
	localparam logic [7:0] OFF_C_DESC = 8'h20;
	localparam logic [7:0] OFF_WP_CTRL = 8'h24;
	localparam logic [7:0] OFF_WP_STAT = 8'h28;
	localparam int BIT_PREV = 0;
	localparam int BIT_CODEC = 1;
	localparam int BIT_FETCH = 0;
	localparam int BIT_STORE = 1;
	localparam int BIT_MASK = 2;
	localparam int BIT_DONE = 3;
	localparam int BIT_WP_EN = 0;
	localparam logic [23:0] WP_KEY = 24'h495349;
	localparam logic [3:0] VIOL_CFG_WRITE = 4'h1;
	localparam logic [31:0] ALIGN_MASK = 32'hffff_fffc;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [31:0] DESC_STEP = 32'h0000_0004;
	localparam logic [31:0] DONE_WORD = 32'h0000_0008;
	localparam logic [1:0] IDX_BASE = 2'h0;
	localparam logic [1:0] IDX_CTRL = 2'h1;
	localparam logic [1:0] IDX_NEXT = 2'h2;
	typedef enum logic [2:0] {
		FS_IDLE,
		FS_READ,
		FS_STORE,
		FS_GAP
	} fetch_state_t;
endpackage

/* File: rtl/camera_dma_channel_control.sv */
// Channel control, descriptor fetch/writeback and write protection for preview and codec DMA.
// Assumes classic Wishbone on both ports, one clock, and a frame_end pulse per channel.
// Behaviour
// RULE1: codec enable strobe one enables codec
// RULE2: preview enable strobe bit0 enables preview
// RULE3: disable bit0 turns preview off, polled
// RULE4: disable bit1 turns codec off, polled
// RULE5: state bit0 shows preview enabled
// RULE6: state bit1 shows codec enabled, reset zero
// RULE7: preview base holds word address
// RULE8: codec base holds word address
// RULE9: preview descriptor pointer word aligned
// RULE10: codec descriptor pointer word aligned
// RULE11: preview control bit0 enables fetch
// RULE12: preview control bit1 enables writeback
// RULE13: preview bit2 low enables done flag
// RULE14: preview writeback sets memory done bit
// RULE15: codec control bit0 enables fetch
// RULE16: codec control bit1 enables writeback
// RULE17: codec bit2 low enables done flag
// RULE18: codec writeback sets memory done bit
// RULE19: keyed write with bit0 enables protection
// RULE20: keyed write bit0 clear disables protection
// RULE21: wrong key leaves protection unchanged
// RULE22: violation field clears on read
// RULE23: fetch loads descriptor, follows next pointer
// RULE24: protection blocks configuration writes
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
module camera_dma_channel_control (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, high
	input wire logic wb_cyc_i, // Slave cycle
	input wire logic wb_stb_i, // Slave strobe
	input wire logic wb_we_i, // Slave write
	input wire logic [7:0] wb_adr_i, // Slave byte address
	input wire logic [3:0] wb_sel_i, // Slave byte selects
	input wire logic [31:0] wb_dat_i, // Slave write data
	output logic [31:0] wb_dat_o, // Slave read data
	output logic wb_ack_o, // Slave ack
	input wire logic [1:0] frame_end_i, // End of frame pulse, bit0 preview
	output logic [31:0] preview_base_o, // Active preview buffer base
	output logic [31:0] codec_base_o, // Active codec buffer base
	output logic [1:0] active_o, // Channel enabled
	output logic [1:0] done_o, // Transfer done pulse
	output logic m_cyc_o, // Memory cycle
	output logic m_stb_o, // Memory strobe
	output logic m_we_o, // Memory write
	output logic [31:0] m_adr_o, // Memory address
	output logic [31:0] m_dat_o, // Memory write data
	input wire logic [31:0] m_dat_i, // Memory read data
	input wire logic m_ack_i // Memory ack
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [1:0] active;
		logic [31:0] p_base;
		logic [31:0] c_base;
		logic [31:0] p_ctrl;
		logic [31:0] c_ctrl;
		logic [31:0] p_desc;
		logic [31:0] c_desc;
		logic wp_en;
		logic [3:0] viol;
		logic [1:0] done;
		logic [1:0] fetch_pend;
		logic [1:0] store_pend;
		cam_dma_pkg::fetch_state_t fs;
		logic ch;
		logic [1:0] idx;
		logic [31:0] cur_desc;
		logic [31:0] p_used;
		logic [31:0] c_used;
		logic cyc;
		logic we;
		logic [31:0] adr;
		logic [31:0] wdat;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic wr;
	logic rd;

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_reg.ack;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
		s_next.done = 2'h0;
		if (rd) begin
			case (wb_adr_i)
				cam_dma_pkg::OFF_STATE: s_next.rdata = {30'h0, s_reg.active}; // RULE5 RULE6
				cam_dma_pkg::OFF_P_BASE: s_next.rdata = s_reg.p_base;
				cam_dma_pkg::OFF_P_CTRL: s_next.rdata = s_reg.p_ctrl;
				cam_dma_pkg::OFF_P_DESC: s_next.rdata = s_reg.p_desc;
				cam_dma_pkg::OFF_C_BASE: s_next.rdata = s_reg.c_base;
				cam_dma_pkg::OFF_C_CTRL: s_next.rdata = s_reg.c_ctrl;
				cam_dma_pkg::OFF_C_DESC: s_next.rdata = s_reg.c_desc;
				cam_dma_pkg::OFF_WP_CTRL: s_next.rdata = {31'h0, s_reg.wp_en};
				cam_dma_pkg::OFF_WP_STAT: begin
					s_next.rdata = {28'h0, s_reg.viol};
					s_next.viol = 4'h0; // RULE22
				end
				default: s_next.rdata = cam_dma_pkg::RESET_WORD;
			endcase
		end
		if (wr) begin
			case (wb_adr_i)
				cam_dma_pkg::OFF_ENABLE: begin
					if (wb_sel_i[0] && wb_dat_i[cam_dma_pkg::BIT_PREV]) begin
						s_next.active[0] = 1'b1; // RULE2
					end
					if (wb_sel_i[0] && wb_dat_i[cam_dma_pkg::BIT_CODEC]) begin
						s_next.active[1] = 1'b1; // RULE1
					end
				end
				cam_dma_pkg::OFF_DISABLE: begin
					if (wb_sel_i[0] && wb_dat_i[cam_dma_pkg::BIT_PREV]) begin
						s_next.active[0] = 1'b0; // RULE3
					end
					if (wb_sel_i[0] && wb_dat_i[cam_dma_pkg::BIT_CODEC]) begin
						s_next.active[1] = 1'b0; // RULE4
					end
				end
				cam_dma_pkg::OFF_P_BASE, cam_dma_pkg::OFF_P_CTRL, cam_dma_pkg::OFF_P_DESC,
				cam_dma_pkg::OFF_C_BASE, cam_dma_pkg::OFF_C_CTRL, cam_dma_pkg::OFF_C_DESC: begin
					if (s_reg.wp_en) begin
						s_next.viol = cam_dma_pkg::VIOL_CFG_WRITE; // RULE24
					end else begin
						case (wb_adr_i)
							cam_dma_pkg::OFF_P_BASE: s_next.p_base =
								merge(s_reg.p_base, wb_dat_i, wb_sel_i) & cam_dma_pkg::ALIGN_MASK; // RULE7
							cam_dma_pkg::OFF_C_BASE: s_next.c_base =
								merge(s_reg.c_base, wb_dat_i, wb_sel_i) & cam_dma_pkg::ALIGN_MASK; // RULE8
							cam_dma_pkg::OFF_P_DESC: begin
								s_next.p_desc = merge(s_reg.p_desc, wb_dat_i, wb_sel_i)
									& cam_dma_pkg::ALIGN_MASK; // RULE9
								s_next.p_used = s_next.p_desc;
							end
							cam_dma_pkg::OFF_C_DESC: begin
								s_next.c_desc = merge(s_reg.c_desc, wb_dat_i, wb_sel_i)
									& cam_dma_pkg::ALIGN_MASK; // RULE10
								s_next.c_used = s_next.c_desc;
							end
							cam_dma_pkg::OFF_P_CTRL: s_next.p_ctrl =
								merge(s_reg.p_ctrl, wb_dat_i, wb_sel_i) & cam_dma_pkg::CTRL_MASK; // RULE11 RULE12
							cam_dma_pkg::OFF_C_CTRL: s_next.c_ctrl =
								merge(s_reg.c_ctrl, wb_dat_i, wb_sel_i) & cam_dma_pkg::CTRL_MASK; // RULE15 RULE16
							default: s_next.viol = s_next.viol;
						endcase
					end
				end
				cam_dma_pkg::OFF_WP_CTRL: begin
					if (wb_sel_i == 4'hf && wb_dat_i[31:8] == cam_dma_pkg::WP_KEY) begin // RULE21
						s_next.wp_en = wb_dat_i[cam_dma_pkg::BIT_WP_EN]; // RULE19 RULE20
					end
				end
				default: s_next.rdata = s_next.rdata;
			endcase
		end
		// ----------------------------------------
		// Descriptor engine: preview first, writeback before fetch per channel
		// ----------------------------------------
		case (s_reg.fs)
			cam_dma_pkg::FS_IDLE: begin
				for (int c = 1; c >= 0; c--) begin
					if (s_reg.store_pend[c] || s_reg.fetch_pend[c]) begin
						s_next.ch = c[0];
					end
				end
				if (s_reg.store_pend != 2'h0 || s_reg.fetch_pend != 2'h0) begin
					s_next.ch = (s_reg.store_pend[0] || s_reg.fetch_pend[0]) ? 1'b0 : 1'b1;
					s_next.cur_desc = s_next.ch ? s_reg.c_desc : s_reg.p_desc;
					s_next.cyc = 1'b1;
					s_next.idx = cam_dma_pkg::IDX_BASE;
					if (s_reg.store_pend[s_next.ch]) begin
						s_next.fs = cam_dma_pkg::FS_STORE;
						s_next.we = 1'b1;
						// Done bit goes to the descriptor just used, not the next one
						s_next.adr = (s_next.ch ? s_reg.c_used : s_reg.p_used)
							+ cam_dma_pkg::DESC_STEP;
						s_next.wdat = (s_next.ch ? s_reg.c_ctrl : s_reg.p_ctrl)
							| cam_dma_pkg::DONE_WORD; // RULE14 RULE18
					end else begin
						s_next.fs = cam_dma_pkg::FS_READ;
						s_next.we = 1'b0;
						s_next.adr = s_next.ch ? s_reg.c_desc : s_reg.p_desc;
					end
				end
			end
			cam_dma_pkg::FS_STORE: begin
				if (m_ack_i) begin
					s_next.cyc = 1'b0;
					s_next.we = 1'b0;
					s_next.store_pend[s_reg.ch] = 1'b0;
					s_next.fs = cam_dma_pkg::FS_GAP;
				end
			end
			cam_dma_pkg::FS_READ: begin
				if (m_ack_i) begin
					s_next.cyc = 1'b0;
					s_next.fs = cam_dma_pkg::FS_GAP;
					case (s_reg.idx)
						cam_dma_pkg::IDX_BASE: begin
							if (s_reg.ch) begin
								s_next.c_base = m_dat_i & cam_dma_pkg::ALIGN_MASK;
							end else begin
								s_next.p_base = m_dat_i & cam_dma_pkg::ALIGN_MASK;
							end
						end
						cam_dma_pkg::IDX_CTRL: begin
							if (s_reg.ch) begin
								s_next.c_ctrl = m_dat_i & cam_dma_pkg::CTRL_MASK;
							end else begin
								s_next.p_ctrl = m_dat_i & cam_dma_pkg::CTRL_MASK;
							end
						end
						default: begin
							if (s_reg.ch) begin
								s_next.c_desc = m_dat_i & cam_dma_pkg::ALIGN_MASK; // RULE23
								s_next.c_used = s_reg.cur_desc;
							end else begin
								s_next.p_desc = m_dat_i & cam_dma_pkg::ALIGN_MASK; // RULE23
								s_next.p_used = s_reg.cur_desc;
							end
							s_next.fetch_pend[s_reg.ch] = 1'b0;
						end
					endcase
					if (s_reg.idx != cam_dma_pkg::IDX_NEXT) begin
						s_next.idx = s_reg.idx + 2'h1;
					end else begin
						s_next.idx = cam_dma_pkg::IDX_BASE;
					end
				end
			end
			cam_dma_pkg::FS_GAP: begin
				if (s_reg.idx != cam_dma_pkg::IDX_BASE) begin
					s_next.fs = cam_dma_pkg::FS_READ;
					s_next.cyc = 1'b1;
					s_next.adr = s_reg.cur_desc + {28'h0, s_reg.idx, 2'h0};
				end else begin
					s_next.fs = cam_dma_pkg::FS_IDLE;
				end
			end
			default: s_next.fs = cam_dma_pkg::FS_IDLE;
		endcase
		// ----------------------------------------
		// Queued work: a new request beats the engine's clear
		// ----------------------------------------
		if (wr && wb_adr_i == cam_dma_pkg::OFF_ENABLE && wb_sel_i[0]) begin
			if (wb_dat_i[cam_dma_pkg::BIT_PREV] && s_reg.p_ctrl[cam_dma_pkg::BIT_FETCH]) begin
				s_next.fetch_pend[0] = 1'b1; // RULE11 RULE23
			end
			if (wb_dat_i[cam_dma_pkg::BIT_CODEC] && s_reg.c_ctrl[cam_dma_pkg::BIT_FETCH]) begin
				s_next.fetch_pend[1] = 1'b1; // RULE15 RULE23
			end
		end
		if (frame_end_i[0] && s_reg.active[0]) begin
			s_next.done[0] = !s_reg.p_ctrl[cam_dma_pkg::BIT_MASK]; // RULE13
			if (s_reg.p_ctrl[cam_dma_pkg::BIT_STORE]) begin
				s_next.store_pend[0] = 1'b1; // RULE12 RULE14
			end
			if (s_reg.p_ctrl[cam_dma_pkg::BIT_FETCH]) begin
				s_next.fetch_pend[0] = 1'b1; // RULE23
			end
		end
		if (frame_end_i[1] && s_reg.active[1]) begin
			s_next.done[1] = !s_reg.c_ctrl[cam_dma_pkg::BIT_MASK]; // RULE17
			if (s_reg.c_ctrl[cam_dma_pkg::BIT_STORE]) begin
				s_next.store_pend[1] = 1'b1; // RULE16 RULE18
			end
			if (s_reg.c_ctrl[cam_dma_pkg::BIT_FETCH]) begin
				s_next.fetch_pend[1] = 1'b1; // RULE23
			end
		end
		if (rst_i) begin
			s_next = '0;
			s_next.fs = cam_dma_pkg::FS_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		s_reg <= s_next;
	end

	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.rdata;
	assign active_o = s_reg.active;
	assign done_o = s_reg.done;
	assign preview_base_o = s_reg.p_base;
	assign codec_base_o = s_reg.c_base;
	assign m_cyc_o = s_reg.cyc;
	assign m_stb_o = s_reg.cyc;
	assign m_we_o = s_reg.we;
	assign m_adr_o = s_reg.adr;
	assign m_dat_o = s_reg.wdat;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_ENABLE_CODEC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
		wr && wb_adr_i == cam_dma_pkg::OFF_ENABLE && wb_sel_i[0] && wb_dat_i[1] |=> active_o[1])
		else $error("codec not enabled");
	AST_ENABLE_PREV: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
		wr && wb_adr_i == cam_dma_pkg::OFF_ENABLE && wb_sel_i[0] && wb_dat_i[0] |=> active_o[0])
		else $error("preview not enabled");
	AST_DISABLE_PREV: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		wr && wb_adr_i == cam_dma_pkg::OFF_DISABLE && wb_sel_i[0] && wb_dat_i[0] |=> !active_o[0])
		else $error("preview not disabled");
	AST_DISABLE_CODEC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
		wr && wb_adr_i == cam_dma_pkg::OFF_DISABLE && wb_sel_i[0] && wb_dat_i[1] |=> !active_o[1])
		else $error("codec not disabled");
	AST_STATE_READ: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
		rd && wb_adr_i == cam_dma_pkg::OFF_STATE |=> wb_dat_o == {30'h0, $past(active_o)})
		else $error("state read wrong");
	AST_DONE_MASK: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
		frame_end_i[0] && active_o[0] |=> done_o[0] == !$past(s_reg.p_ctrl[cam_dma_pkg::BIT_MASK]))
		else $error("preview done flag wrong");
	AST_KEY: assert property (@(posedge clk_i) disable iff (rst_i) // RULE21
		wr && wb_adr_i == cam_dma_pkg::OFF_WP_CTRL && wb_dat_i[31:8] != cam_dma_pkg::WP_KEY
		|=> $stable(s_reg.wp_en))
		else $error("bad key changed protection");
	AST_PROTECT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE24
		wr && s_reg.wp_en && wb_adr_i == cam_dma_pkg::OFF_P_BASE && s_reg.fs == cam_dma_pkg::FS_IDLE
		|=> $stable(s_reg.p_base) && s_reg.viol == cam_dma_pkg::VIOL_CFG_WRITE)
		else $error("protected write took effect");
	AST_VIOL_CLR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
		rd && wb_adr_i == cam_dma_pkg::OFF_WP_STAT && !wr |=> s_reg.viol == 4'h0)
		else $error("violation not cleared");
	AST_STATE_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
		$past(rst_i) |-> active_o == 2'h0 && done_o == 2'h0 && !wb_ack_o)
		else $error("outputs not cleared by reset");
	AST_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7 RULE8 RULE9 RULE10
		((s_reg.p_base | s_reg.c_base | s_reg.p_desc | s_reg.c_desc) & ~cam_dma_pkg::ALIGN_MASK)
		== cam_dma_pkg::RESET_WORD)
		else $error("address register not word aligned");
	AST_DONE_CODEC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
		frame_end_i[1] && active_o[1] |=> done_o[1] == !$past(s_reg.c_ctrl[cam_dma_pkg::BIT_MASK]))
		else $error("codec done flag wrong");
	AST_KEY_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19 RULE20
		wr && wb_adr_i == cam_dma_pkg::OFF_WP_CTRL && wb_sel_i == 4'hf && wb_dat_i[31:8] ==
		cam_dma_pkg::WP_KEY |=> s_reg.wp_en == $past(wb_dat_i[cam_dma_pkg::BIT_WP_EN]))
		else $error("keyed write did not set protection");
	AST_FETCH_PREV: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11 RULE23
		s_reg.fs == cam_dma_pkg::FS_IDLE && s_reg.fetch_pend[0] && !s_reg.store_pend[0]
		|=> m_cyc_o && !m_we_o && m_adr_o == $past(s_reg.p_desc))
		else $error("preview fetch not started at descriptor");
	AST_FETCH_CODEC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15 RULE23
		s_reg.fs == cam_dma_pkg::FS_IDLE && s_reg.fetch_pend == 2'h2 && s_reg.store_pend == 2'h0
		|=> m_cyc_o && !m_we_o && m_adr_o == $past(s_reg.c_desc))
		else $error("codec fetch not started at descriptor");
	AST_STORE_PREV: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12 RULE14
		s_reg.fs == cam_dma_pkg::FS_IDLE && s_reg.store_pend[0]
		|=> m_cyc_o && m_we_o && m_adr_o == $past(s_reg.p_used) + cam_dma_pkg::DESC_STEP)
		else $error("preview writeback address wrong");
	AST_STORE_WORD: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14 RULE18
		m_cyc_o && m_we_o |-> m_dat_o[cam_dma_pkg::BIT_DONE])
		else $error("writeback without done bit");
endmodule

/* File: test/cam_mem_model.sv */
// Behavioural system memory on the block's memory master port.
// Assumes single classic Wishbone cycles and word-aligned byte addresses below 0x40.
`timescale 1ns/10ps
module cam_mem_model (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, high
	input wire logic cyc_i, // Cycle
	input wire logic stb_i, // Strobe
	input wire logic we_i, // Write
	input wire logic [31:0] adr_i, // Byte address
	input wire logic [31:0] dat_i, // Write data
	input wire logic [3:0] wait_i, // Wait states before ack
	output logic [31:0] dat_o, // Read data
	output logic ack_o // Ack
);
	logic [31:0] mem_words [0:15];
	logic [3:0] cnt;
	initial begin
		for (int i = 0; i < 16; i++) mem_words[i] = 32'h0;
	end
	// Outside reset, the data line toggles whenever no answer is being given
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			cnt <= 4'h0;
			dat_o <= 32'h0;
		end else if (cyc_i && stb_i && !ack_o && cnt == wait_i) begin
			ack_o <= 1'b1;
			cnt <= 4'h0;
			if (we_i) mem_words[adr_i[5:2]] <= dat_i;
			else dat_o <= mem_words[adr_i[5:2]];
		end else begin
			ack_o <= 1'b0;
			dat_o <= ~dat_o;
			if (cyc_i && stb_i && !ack_o) cnt <= cnt + 4'h1;
		end
	end
endmodule

/* File: test/camera_dma_channel_control_test.sv */
// Self-checking bench for the camera DMA channel control.
// Assumes the memory model above on the master port.
`timescale 1ns/10ps
module camera_dma_channel_control_test;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf, mem_wait = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, pbase, cbase, m_adr, m_wdat, m_rdat;
	logic [1:0] frame_end = 2'h0, active, done;
	logic ack, m_cyc, m_stb, m_we, m_ack;
	int fails = 0, checked = 0, done_cnt [2] = '{0, 0};
	camera_dma_channel_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .frame_end_i(frame_end), .preview_base_o(pbase), .codec_base_o(cbase),
		.active_o(active), .done_o(done), .m_cyc_o(m_cyc), .m_stb_o(m_stb), .m_we_o(m_we),
		.m_adr_o(m_adr), .m_dat_o(m_wdat), .m_dat_i(m_rdat), .m_ack_i(m_ack));
	cam_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(m_cyc), .stb_i(m_stb), .we_i(m_we),
		.adr_i(m_adr), .dat_i(m_wdat), .wait_i(mem_wait), .dat_o(m_rdat), .ack_o(m_ack));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (done[0] === 1'b1) done_cnt[0]++;
		if (done[1] === 1'b1) done_cnt[1]++;
	end
	// ---------------------------------------------
	// Shared tasks
	// ---------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(name, q, exp);
	endtask
	task automatic poll(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		for (int n = 0; n < 40; n++) begin
			bus(1'b0, a, 32'h0, q);
			if (q === exp) break;
		end
		check(name, q, exp);
	endtask
	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task automatic reset_values;
		check("active reset", {30'h0, active}, 32'h0);
		rd("state", cam_dma_pkg::OFF_STATE, 32'h0);
		rd("p_ctrl", cam_dma_pkg::OFF_P_CTRL, 32'h0);
		rd("unmapped", 8'h3c, 32'h0);
	endtask
	task automatic address_regs;
		logic [7:0] offs [4] = '{cam_dma_pkg::OFF_P_BASE, cam_dma_pkg::OFF_C_BASE,
			cam_dma_pkg::OFF_P_DESC, cam_dma_pkg::OFF_C_DESC};
		foreach (offs[i]) begin
			wr(offs[i], 32'hffff_ffff);
			rd("addr reg", offs[i], 32'hffff_fffc);
		end
	endtask
	task automatic enables;
		wr(cam_dma_pkg::OFF_ENABLE, 32'h1);
		rd("state p", cam_dma_pkg::OFF_STATE, 32'h1);
		wr(cam_dma_pkg::OFF_ENABLE, 32'h2);
		rd("state pc", cam_dma_pkg::OFF_STATE, 32'h3);
		wr(cam_dma_pkg::OFF_ENABLE, 32'h0);
		check("active", {30'h0, active}, 32'h3);
		wr(cam_dma_pkg::OFF_DISABLE, 32'h1);
		poll("state c", cam_dma_pkg::OFF_STATE, 32'h2);
		wr(cam_dma_pkg::OFF_DISABLE, 32'h2);
		poll("state none", cam_dma_pkg::OFF_STATE, 32'h0);
	endtask
	task automatic chan_flow(input int ch, input logic [31:0] ctl, input logic [3:0] wt);
		int i0, i1, d0c;
		logic [31:0] d0, d1, b0, b1;
		logic [7:0] coff, doff;
		i0 = ch ? 12 : 4;
		i1 = ch ? 1 : 8;
		d0 = i0 * 4;
		d1 = i1 * 4;
		b0 = 32'h1000 + ch * 32'h100;
		b1 = b0 + 32'h40;
		coff = ch ? cam_dma_pkg::OFF_C_CTRL : cam_dma_pkg::OFF_P_CTRL;
		doff = ch ? cam_dma_pkg::OFF_C_DESC : cam_dma_pkg::OFF_P_DESC;
		mem.mem_words[i0] = b0;
		mem.mem_words[i0 + 1] = ctl;
		mem.mem_words[i0 + 2] = d1;
		mem.mem_words[i1] = b1;
		mem.mem_words[i1 + 1] = ctl;
		mem.mem_words[i1 + 2] = d0;
		mem_wait <= wt;
		wr(coff, ctl);
		wr(doff, d0);
		wr(cam_dma_pkg::OFF_ENABLE, 32'h1 << ch);
		poll("next ptr", doff, d1);
		check("base", ch ? cbase : pbase, b0);
		d0c = done_cnt[ch];
		@(posedge clk_i);
		frame_end[ch] <= 1'b1;
		@(posedge clk_i);
		frame_end[ch] <= 1'b0;
		poll("follow", doff, d0);
		check("base 2", ch ? cbase : pbase, b1);
		check("done bit", mem.mem_words[i0 + 1], ctl | 32'h8);
		check("done flags", done_cnt[ch] - d0c, ctl[2] ? 32'h0 : 32'h1);
		wr(cam_dma_pkg::OFF_DISABLE, 32'h1 << ch);
		poll("off", cam_dma_pkg::OFF_STATE, 32'h0);
	endtask
	task automatic protection;
		wr(cam_dma_pkg::OFF_P_BASE, 32'h100);
		wr(cam_dma_pkg::OFF_WP_CTRL, 32'h1234_5601);
		rd("wp bad key", cam_dma_pkg::OFF_WP_CTRL, 32'h0);
		wr(cam_dma_pkg::OFF_WP_CTRL, {cam_dma_pkg::WP_KEY, 8'h01});
		rd("wp on", cam_dma_pkg::OFF_WP_CTRL, 32'h1);
		wr(cam_dma_pkg::OFF_P_BASE, 32'h200);
		rd("locked", cam_dma_pkg::OFF_P_BASE, 32'h100);
		rd("viol", cam_dma_pkg::OFF_WP_STAT, 32'h1);
		rd("viol clr", cam_dma_pkg::OFF_WP_STAT, 32'h0);
		wr(cam_dma_pkg::OFF_WP_CTRL, 32'h1234_5600);
		rd("wp kept", cam_dma_pkg::OFF_WP_CTRL, 32'h1);
		wr(cam_dma_pkg::OFF_WP_CTRL, {cam_dma_pkg::WP_KEY, 8'h00});
		rd("wp off", cam_dma_pkg::OFF_WP_CTRL, 32'h0);
		wr(cam_dma_pkg::OFF_P_BASE, 32'h200);
		rd("unlocked", cam_dma_pkg::OFF_P_BASE, 32'h200);
	endtask
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ---------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		reset_values();
		address_regs();
		enables();
		chan_flow(0, 32'h3, 4'h0);
		chan_flow(1, 32'h7, 4'h3);
		protection();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		print_verdict();
	end
endmodule
